// ===== core/mfl_pkg.sv
// mfl_pkg: constants and types for the frame-limit and identification register bank.
// assumes a 32-bit AXI4-Lite master with a 12-bit byte address on the management clock.
package mfl_pkg;

    // bus geometry
    localparam int ADDR_W = 12;

    // register byte offsets
    localparam logic [11:0] RX_MAC_CFG_OFF = 12'h404;
    localparam logic [11:0] TX_MAC_CFG_OFF = 12'h408;
    localparam logic [11:0] RX_LIMIT_OFF   = 12'h414;
    localparam logic [11:0] TX_LIMIT_OFF   = 12'h418;
    localparam logic [11:0] REV_OFF        = 12'h4F8;
    localparam logic [11:0] CAP_OFF        = 12'h4FC;

    // field positions in the mac configuration words
    localparam int JUMBO_BIT = 30;
    localparam int TAG_BIT   = 27;

    // field positions in the frame limit words
    localparam int OVR_BIT = 16;
    localparam int LEN_W   = 15;

    // field positions in the revision word
    localparam int MAJOR_LSB = 24;
    localparam int MINOR_LSB = 16;
    localparam int PATCH_LSB = 0;

    // field positions in the capability word
    localparam int FILT_BIT = 10;
    localparam int HALF_BIT = 9;
    localparam int STAT_BIT = 8;
    localparam int GIG_BIT  = 2;
    localparam int FAST_BIT = 1;
    localparam int TEN_BIT  = 0;

    // standard frame lengths and reset value of the programmable lengths
    localparam logic [14:0] STD_LEN = 15'h05EE;
    localparam logic [14:0] TAG_LEN = 15'h05F2;
    localparam logic [14:0] LEN_RST = STD_LEN;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } mfl_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } mfl_axi_rsp_t;

    typedef struct packed {
        logic             no_limit;
        logic [LEN_W-1:0] max_len;
    } mfl_limit_t;

    typedef struct packed {
        logic              aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_have;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              rx_jumbo;
        logic              rx_tag;
        logic              tx_jumbo;
        logic              tx_tag;
        logic              rx_ovr;
        logic [LEN_W-1:0]  rx_len;
        logic              tx_ovr;
        logic [LEN_W-1:0]  tx_len;
        mfl_limit_t        rx_lim;
        mfl_limit_t        tx_lim;
    } mfl_state_t;

    localparam mfl_state_t STATE_RST = '{
        rx_len:  LEN_RST,
        tx_len:  LEN_RST,
        rx_lim:  '{no_limit: 1'b0, max_len: STD_LEN},
        tx_lim:  '{no_limit: 1'b0, max_len: STD_LEN},
        default: '0
    };

endpackage

// ===== core/mfl_regs.sv
// mfl_regs: frame-limit configuration and identification registers of an ethernet mac.
// assumes one clock (aclk), a synchronous active-low reset and an AXI4-Lite master.
//
// Summary of operation
// - no override: rx limit 1518, tagged 1522
// - rx override: limit is programmed rx length
// - jumbo enable removes every length limit
// - rx length bits 14:0, rw, reset 1518
// - no override: tx limit 1518, tagged 1522
// - tx length bits 14:0, rw, reset 1518
// - revision word: major, minor, patch, read-only
// - patch reads 0 unpatched, 1 first patch
// - capabilities: filter 10, half 9, stats 8
// - capabilities: gigabit 2, fast 1, ten 0
// - jumbo enable is config bit 30
// - tag support is config bit 27
`timescale 1ns/1ps
module mfl_regs #(
    parameter logic [7:0] REV_MAJOR  = 8'h01, // arbitrary value
    parameter logic [7:0] REV_MINOR  = 8'h00, // arbitrary value
    parameter logic [7:0] REV_PATCH  = 8'h00, // arbitrary value
    parameter bit         HAS_FILTER = 1'b1,
    parameter bit         HAS_HALF   = 1'b1,
    parameter bit         HAS_STATS  = 1'b1,
    parameter bit         HAS_GIG    = 1'b1,
    parameter bit         HAS_FAST   = 1'b1,
    parameter bit         HAS_TEN    = 1'b1
) (
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // register bus
    input  wire mfl_pkg::mfl_axi_req_t axi_req,
    output mfl_pkg::mfl_axi_rsp_t      axi_rsp,
    // limits applied by the frame datapath
    output mfl_pkg::mfl_limit_t        rx_limit,
    output mfl_pkg::mfl_limit_t        tx_limit
);
    import mfl_pkg::*;

    mfl_state_t  s_q;
    mfl_state_t  s_d;
    logic        aw_hs;
    logic        w_hs;
    logic        ar_hs;
    logic        wr_go;
    logic [31:0] wr_new;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == RX_MAC_CFG_OFF) || (a == TX_MAC_CFG_OFF) || (a == RX_LIMIT_OFF) ||
               (a == TX_LIMIT_OFF) || (a == REV_OFF) || (a == CAP_OFF);
    endfunction

    // reserved and unmapped bits stay zero
    function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a, input mfl_state_t s);
        logic [31:0] v;
        v = '0;
        case (a)
            RX_MAC_CFG_OFF: begin
                v[JUMBO_BIT] = s.rx_jumbo;
                v[TAG_BIT]   = s.rx_tag;
            end
            TX_MAC_CFG_OFF: begin
                v[JUMBO_BIT] = s.tx_jumbo;
                v[TAG_BIT]   = s.tx_tag;
            end
            RX_LIMIT_OFF: begin
                v[OVR_BIT]     = s.rx_ovr;
                v[LEN_W-1:0]   = s.rx_len;
            end
            TX_LIMIT_OFF: begin
                v[OVR_BIT]     = s.tx_ovr;
                v[LEN_W-1:0]   = s.tx_len;
            end
            REV_OFF: begin
                v[MAJOR_LSB +: 8] = REV_MAJOR;
                v[MINOR_LSB +: 8] = REV_MINOR;
                v[PATCH_LSB +: 8] = REV_PATCH;
            end
            CAP_OFF: begin
                v[FILT_BIT] = HAS_FILTER;
                v[HALF_BIT] = HAS_HALF;
                v[STAT_BIT] = HAS_STATS;
                v[GIG_BIT]  = HAS_GIG;
                v[FAST_BIT] = HAS_FAST;
                v[TEN_BIT]  = HAS_TEN;
            end
            default: v = '0;
        endcase
        return v;
    endfunction

    // byte lanes without a strobe keep their old contents
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return v;
    endfunction

    function automatic mfl_limit_t pick_limit(input logic jumbo, input logic ovr,
                                              input logic tag, input logic [LEN_W-1:0] len);
        mfl_limit_t l;
        l.no_limit = jumbo;
        if (ovr) begin
            l.max_len = len;
        end else if (tag) begin
            l.max_len = TAG_LEN;
        end else begin
            l.max_len = STD_LEN;
        end
        return l;
    endfunction

    // a held write blocks new address and data until its answer is taken
    assign axi_rsp.awready = !s_q.aw_have && !s_q.bvalid;
    assign axi_rsp.wready  = !s_q.w_have && !s_q.bvalid;
    assign axi_rsp.arready = !s_q.rvalid;
    assign axi_rsp.bvalid  = s_q.bvalid;
    assign axi_rsp.bresp   = s_q.bresp;
    assign axi_rsp.rvalid  = s_q.rvalid;
    assign axi_rsp.rdata   = s_q.rdata;
    assign axi_rsp.rresp   = s_q.rresp;
    assign rx_limit        = s_q.rx_lim;
    assign tx_limit        = s_q.tx_lim;

    always_comb begin
        s_d    = s_q;
        aw_hs  = axi_req.awvalid && axi_rsp.awready;
        w_hs   = axi_req.wvalid && axi_rsp.wready;
        ar_hs  = axi_req.arvalid && axi_rsp.arready;
        wr_go  = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        wr_new = merge(rd_word(s_q.aw_addr, s_q), s_q.w_data, s_q.w_strb);

        if (aw_hs) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = {axi_req.awaddr[ADDR_W-1:2], 2'h0};
        end
        if (w_hs) begin
            s_d.w_have = 1'b1;
            s_d.w_data = axi_req.wdata;
            s_d.w_strb = axi_req.wstrb;
        end
        if (s_q.bvalid && axi_req.bready) begin
            s_d.bvalid = 1'b0;
        end

        // read-only and unmapped words take no write; reserved bits are dropped
        if (wr_go) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = is_mapped(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            case (s_q.aw_addr)
                RX_MAC_CFG_OFF: begin
                    s_d.rx_jumbo = wr_new[JUMBO_BIT];
                    s_d.rx_tag   = wr_new[TAG_BIT];
                end
                TX_MAC_CFG_OFF: begin
                    s_d.tx_jumbo = wr_new[JUMBO_BIT];
                    s_d.tx_tag   = wr_new[TAG_BIT];
                end
                RX_LIMIT_OFF: begin
                    s_d.rx_ovr = wr_new[OVR_BIT];
                    s_d.rx_len = wr_new[LEN_W-1:0];
                end
                TX_LIMIT_OFF: begin
                    s_d.tx_ovr = wr_new[OVR_BIT];
                    s_d.tx_len = wr_new[LEN_W-1:0];
                end
                default: s_d.bvalid = 1'b1;
            endcase
        end

        if (s_q.rvalid && axi_req.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (ar_hs) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_word({axi_req.araddr[ADDR_W-1:2], 2'h0}, s_q);
            s_d.rresp  = is_mapped({axi_req.araddr[ADDR_W-1:2], 2'h0}) ? RESP_OKAY : RESP_SLVERR;
        end

        // limits are registered so the datapath sees glitch-free values
        s_d.rx_lim = pick_limit(s_q.rx_jumbo, s_q.rx_ovr, s_q.rx_tag, s_q.rx_len);
        s_d.tx_lim = pick_limit(s_q.tx_jumbo, s_q.tx_ovr, s_q.tx_tag, s_q.tx_len);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence wr_pending_s;
        s_q.aw_have && s_q.w_have && !s_q.bvalid;
    endsequence

    sequence rd_taken_s(logic [ADDR_W-1:0] off);
        ar_hs && (axi_req.araddr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endsequence

    std_rx_limit_a: assert property (
        (!s_q.rx_jumbo && !s_q.rx_ovr) |=>
            !rx_limit.no_limit && (rx_limit.max_len == ($past(s_q.rx_tag) ? TAG_LEN : STD_LEN)))
        else $error("rx standard limit wrong");

    ovr_rx_limit_a: assert property (
        s_q.rx_ovr |=> rx_limit.max_len == $past(s_q.rx_len))
        else $error("rx programmed limit not applied");

    jumbo_free_a: assert property (
        1'b1 |=> (rx_limit.no_limit == $past(s_q.rx_jumbo)) &&
                 (tx_limit.no_limit == $past(s_q.tx_jumbo)))
        else $error("jumbo enable not reflected");

    rx_readback_a: assert property (
        rd_taken_s(RX_LIMIT_OFF) |=> axi_rsp.rvalid && (axi_rsp.rresp == RESP_OKAY) &&
            (axi_rsp.rdata == {15'h0000, $past(s_q.rx_ovr), 1'h0, $past(s_q.rx_len)}))
        else $error("rx limit word readback wrong");

    std_tx_limit_a: assert property (
        (!s_q.tx_jumbo && !s_q.tx_ovr) |=>
            !tx_limit.no_limit && (tx_limit.max_len == ($past(s_q.tx_tag) ? TAG_LEN : STD_LEN)))
        else $error("tx standard limit wrong");

    ovr_tx_limit_a: assert property (
        s_q.tx_ovr |=> tx_limit.max_len == $past(s_q.tx_len))
        else $error("tx programmed limit not applied");

    tx_readback_a: assert property (
        rd_taken_s(TX_LIMIT_OFF) |=> axi_rsp.rvalid &&
            (axi_rsp.rdata == {15'h0000, $past(s_q.tx_ovr), 1'h0, $past(s_q.tx_len)}))
        else $error("tx limit word readback wrong");

    rev_word_a: assert property (
        rd_taken_s(REV_OFF) |=> axi_rsp.rvalid &&
            (axi_rsp.rdata == {REV_MAJOR, REV_MINOR, 8'h00, REV_PATCH}))
        else $error("revision word wrong");

    cap_word_a: assert property (
        rd_taken_s(CAP_OFF) |=> axi_rsp.rvalid && (axi_rsp.rdata ==
            {21'h000000, HAS_FILTER, HAS_HALF, HAS_STATS, 5'h00, HAS_GIG, HAS_FAST, HAS_TEN}))
        else $error("capability word wrong");

    bad_write_a: assert property (
        wr_pending_s ##0 !is_mapped(s_q.aw_addr) |=>
            axi_rsp.bvalid && (axi_rsp.bresp == RESP_SLVERR) && $stable(s_q.rx_len) &&
            $stable(s_q.tx_len) && $stable(s_q.rx_ovr) && $stable(s_q.tx_ovr))
        else $error("unmapped write had an effect");

    sequence full_write_s(logic [ADDR_W-1:0] off);
        wr_pending_s ##0 (s_q.aw_addr == off) && (s_q.w_strb == 4'hF);
    endsequence

    rx_write_a: assert property (
        full_write_s(RX_LIMIT_OFF) |=> (s_q.rx_len == $past(s_q.w_data[LEN_W-1:0])) &&
            (s_q.rx_ovr == $past(s_q.w_data[OVR_BIT])) && (axi_rsp.bresp == RESP_OKAY))
        else $error("rx limit write not stored");

    tx_write_a: assert property (
        full_write_s(TX_LIMIT_OFF) |=> (s_q.tx_len == $past(s_q.w_data[LEN_W-1:0])) &&
            (s_q.tx_ovr == $past(s_q.w_data[OVR_BIT])) && (axi_rsp.bresp == RESP_OKAY))
        else $error("tx limit write not stored");

    tx_cfg_write_a: assert property (
        full_write_s(TX_MAC_CFG_OFF) |=> (s_q.tx_jumbo == $past(s_q.w_data[JUMBO_BIT])) &&
            (s_q.tx_tag == $past(s_q.w_data[TAG_BIT])))
        else $error("tx mac config write not stored");

    rx_cfg_write_a: assert property (
        full_write_s(RX_MAC_CFG_OFF) |=> (s_q.rx_jumbo == $past(s_q.w_data[JUMBO_BIT])) &&
            (s_q.rx_tag == $past(s_q.w_data[TAG_BIT])))
        else $error("rx mac config write not stored");

    ro_write_a: assert property (
        wr_pending_s ##0 ((s_q.aw_addr == REV_OFF) || (s_q.aw_addr == CAP_OFF)) |=>
            (axi_rsp.bresp == RESP_OKAY) && $stable(s_q.rx_len) && $stable(s_q.tx_len) &&
            $stable(s_q.rx_ovr) && $stable(s_q.tx_ovr) && $stable(s_q.tx_jumbo) &&
            $stable(s_q.tx_tag))
        else $error("read-only write had an effect");

    bad_read_a: assert property (
        ar_hs && !is_mapped({axi_req.araddr[ADDR_W-1:2], 2'h0}) |=>
            axi_rsp.rvalid && (axi_rsp.rdata == 32'h00000000) &&
            (axi_rsp.rresp == RESP_SLVERR))
        else $error("unmapped read not refused");

    rst_len_a: assert property (
        $rose(aresetn) |-> (s_q.rx_len == LEN_RST) && (s_q.tx_len == LEN_RST) &&
            !s_q.rx_ovr && !s_q.tx_ovr)
        else $error("length fields not at reset value");

endmodule

// ===== testbench/test_mfl_regs.sv
// test_mfl_regs: self-checking bench for the frame-limit and identification registers.
// assumes mfl_pkg and mfl_regs are compiled first; drives the AXI4-Lite port directly.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module test_mfl_regs;
    import mfl_pkg::*;
    localparam logic [7:0] P_MAJ = 8'h03; // arbitrary value
    localparam logic [7:0] P_MIN = 8'h02; // arbitrary value
    localparam logic [7:0] P_PAT = 8'h01;
    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    mfl_axi_req_t  req = '0;
    mfl_axi_rsp_t  rsp;
    mfl_limit_t    rx_limit;
    mfl_limit_t    tx_limit;
    int            fails = 0;
    int            checks = 0;
    logic [31:0]   seed = 32'h0014EBC2;
    logic [31:0]   rd;
    logic [1:0]    rs;
    logic [2:0]    m;
    logic [14:0]   rl;
    logic [14:0]   tl;
    logic [31:0]   d;

    always #20 aclk = ~aclk;

    // half-duplex and 10 Mb/s left out so the capability word is not all ones;
    // filter and statistics keep their default of present
    mfl_regs #(.REV_MAJOR(P_MAJ), .REV_MINOR(P_MIN), .REV_PATCH(P_PAT), .HAS_HALF(1'b0),
        .HAS_GIG(1'b1), .HAS_FAST(1'b1), .HAS_TEN(1'b0))
    i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .rx_limit(rx_limit), .tx_limit(tx_limit));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic mfl_limit_t exp_lim(input logic j, input logic t, input logic o,
                                           input logic [14:0] len);
        mfl_limit_t e;
        e.no_limit = j;
        e.max_len  = o ? len : (t ? TAG_LEN : STD_LEN);
        return e;
    endfunction

    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic timeout();
        fails++;
        $display("[ERR] %0t bus answer never came", $time);
        end_sim();
    endtask

    // responses are read right after the edge, so they are the values the design sampled
    task automatic wr(input logic [11:0] a, input logic [31:0] dat, input logic [3:0] s,
                      output logic [1:0] r);
        bit done;
        done = 1'b0;
        r = 2'h3;
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= dat;
        req.wstrb   <= s;
        req.bready  <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) begin
                r = rsp.bresp;
                req.bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) timeout();
        // one idle edge so the next call never re-raises a signal released in this step
        @(posedge aclk);
    endtask

    task automatic rdw(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] r);
        bit done;
        done = 1'b0;
        dat = 32'h00000000;
        r = 2'h3;
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) begin
                dat = rsp.rdata;
                r = rsp.rresp;
                req.rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) timeout();
        @(posedge aclk);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(rx_limit, exp_lim(1'b0, 1'b0, 1'b0, 15'h0000))
        `CHK(tx_limit, exp_lim(1'b0, 1'b0, 1'b0, 15'h0000))
        rdw(RX_LIMIT_OFF, rd, rs);
        `CHK({rd, rs}, {32'h000005EE, RESP_OKAY})
        rdw(TX_LIMIT_OFF, rd, rs);
        `CHK({rd, rs}, {32'h000005EE, RESP_OKAY})
        rdw(REV_OFF, rd, rs);
        `CHK({rd, rs}, {P_MAJ, P_MIN, 8'h00, P_PAT, RESP_OKAY})
        rdw(CAP_OFF, rd, rs);
        `CHK({rd, rs}, {32'h00000506, RESP_OKAY})
        wr(REV_OFF, 32'hFFFFFFFF, 4'hF, rs);
        `CHK(rs, RESP_OKAY)
        wr(CAP_OFF, 32'h00000000, 4'hF, rs);
        `CHK(rs, RESP_OKAY)
        rdw(REV_OFF, rd, rs);
        `CHK(rd, {P_MAJ, P_MIN, 8'h00, P_PAT})
        rdw(CAP_OFF, rd, rs);
        `CHK(rd, 32'h00000506)
        wr(12'h420, 32'h12345678, 4'hF, rs);
        `CHK(rs, RESP_SLVERR)
        rdw(12'h420, rd, rs);
        `CHK({rd, rs}, {32'h0, RESP_SLVERR})
        // first eight passes walk every jumbo/tag/override mix, then random ones
        for (int i = 0; i < 14; i++) begin
            seed = lfsr(seed);
            m  = (i < 8) ? i[2:0] : seed[2:0];
            rl = (i == 0) ? 15'h7FFF : (i == 1) ? 15'h0000 : seed[30:16];
            seed = lfsr(seed);
            tl = (i == 2) ? 15'h7FFF : seed[14:0];
            d = (seed & 32'hB7FFFFFF) | {1'b0, m[2], 2'b0, m[1], 27'h0};
            wr(RX_MAC_CFG_OFF, d, 4'hF, rs);
            d = (~seed & 32'hB7FFFFFF) | {1'b0, m[0], 2'b0, m[2], 27'h0};
            wr(TX_MAC_CFG_OFF, d, 4'hF, rs);
            wr(RX_LIMIT_OFF, {seed[31:17], m[0], seed[15], rl}, 4'hF, rs);
            wr(TX_LIMIT_OFF, {~seed[31:17], m[1], ~seed[15], tl}, 4'hF, rs);
            rdw(RX_LIMIT_OFF, rd, rs);
            `CHK(rd, {15'h0, m[0], 1'b0, rl})
            rdw(TX_LIMIT_OFF, rd, rs);
            `CHK(rd, {15'h0, m[1], 1'b0, tl})
            rdw(TX_MAC_CFG_OFF, rd, rs);
            `CHK(rd, {1'b0, m[0], 2'b0, m[2], 27'h0})
            rdw(RX_MAC_CFG_OFF, rd, rs);
            `CHK({rd, rs}, {1'b0, m[2], 2'b0, m[1], 27'h0, RESP_OKAY})
            @(posedge aclk);
            `CHK(rx_limit, exp_lim(m[2], m[1], m[0], rl))
            `CHK(tx_limit, exp_lim(m[0], m[2], m[1], tl))
        end
        wr(RX_LIMIT_OFF, 32'hFFFFFFAB, 4'h1, rs);
        rdw(RX_LIMIT_OFF, rd, rs);
        `CHK(rd, {15'h0, m[0], 1'b0, rl[14:8], 8'hAB})
        // a reset in mid-run must bring back the defaults over programmed values
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(rx_limit, exp_lim(1'b0, 1'b0, 1'b0, 15'h0000))
        `CHK(tx_limit, exp_lim(1'b0, 1'b0, 1'b0, 15'h0000))
        rdw(RX_LIMIT_OFF, rd, rs);
        `CHK({rd, rs}, {32'h000005EE, RESP_OKAY})
        rdw(TX_LIMIT_OFF, rd, rs);
        `CHK({rd, rs}, {32'h000005EE, RESP_OKAY})
        rdw(TX_MAC_CFG_OFF, rd, rs);
        `CHK(rd, 32'h00000000)
        end_sim();
    end
endmodule
